// File: dummy_end_marker_never_used.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// File: mgmt_params.svh
/*
   Constants for the PHY management poller: register byte addresses, field positions,
   reset values, frame layout and management clock timing.
   Assumes a 250 MHz core clock and 32-bit APB data.
*/
`ifndef MGMT_PARAMS_SVH
`define MGMT_PARAMS_SVH

// register byte addresses
`define ADDR_VERSION            32'h01c83800
`define ADDR_CONTROL            32'h01c83804
`define ADDR_PHY_ALIVE_MAP      32'h01c83808
`define ADDR_PHY_LINK_MAP       32'h01c8380c
`define ADDR_LINK_IRQ_RAW       32'h01c83810
`define ADDR_LINK_IRQ_MASKED    32'h01c83814
`define ADDR_CMD_DONE_IRQ_RAW   32'h01c83818
`define ADDR_CMD_DONE_IRQ_MASKED 32'h01c8381c
`define ADDR_CMD_DONE_MASK_SET  32'h01c83820
`define ADDR_CMD_DONE_MASK_CLR  32'h01c83824
`define ADDR_ACCESS_CMD_FIRST   32'h01c83828
`define ADDR_ACCESS_CMD_SECOND  32'h01c8382c
`define ADDR_PHY_SELECT_FIRST   32'h01c83830
`define ADDR_PHY_SELECT_SECOND  32'h01c83834

// field positions
`define CTRL_IDLE_BIT           31
`define CTRL_ENABLE_BIT         30
`define IRQ_FIRST_MAC_BIT       0
`define CMD_GO_BIT              31
`define CMD_WRITE_BIT           30
`define CMD_ACK_BIT             29
`define CMD_REG_LSB             21
`define CMD_PHY_LSB             16
`define SEL_LINK_INT_BIT        6
`define SEL_PHY_LSB             0

// reset values
`define CLKDIV_RESET            16'h0031
`define POLL_EN_RESET           1'b1
`define VERSION_RESET           32'h00010001

// frame layout, bit 0 is the first preamble bit
`define FRAME_PREAMBLE          32'hffffffff
`define FRAME_START             2'b01
`define FRAME_OP_READ           2'b10
`define FRAME_OP_WRITE          2'b01
`define FRAME_TA_WRITE          2'b10
`define FRAME_IDLE_DATA         16'hffff
`define FRAME_RELEASE_BIT       6'd46
`define FRAME_ACK_BIT           6'd47
`define FRAME_DATA_FIRST_BIT    6'd48
`define FRAME_LAST_BIT          6'd63
`define POLL_REG_ADDR           5'h01
`define LINK_STATUS_BIT         2

// management clock timing
`define CORE_CLK_PERIOD_NS      4
`define MGMT_CLK_MIN_HALF_NS    180
`define MGMT_CLK_MIN_HALF_CYC   ((`MGMT_CLK_MIN_HALF_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)

`endif

// File: mgmt_pkg.sv
/*
   Types for the PHY management poller: engine states, pin bundle and the whole
   module state as one packed struct.
   Assumes the constants of mgmt_params.svh.
*/
`default_nettype none
package mgmt_pkg;

   // frame engine states
   typedef enum logic [1:0] {
      ENG_IDLE,
      ENG_FRAME
   } eng_state_t;

   // management bus pins
   typedef struct packed {
      logic mgmt_clock_pin;
      logic data_out;
      logic data_oe;
   } mgmt_pins_t;

   // all state of the poller
   typedef struct packed {
      eng_state_t  st;
      logic [63:0] shift;
      logic [5:0]  bit_cnt;
      logic [16:0] div_cnt;
      logic [15:0] rdata;
      logic        ack;
      logic        user_frame;
      logic        is_write;
      logic [4:0]  poll_addr;
      mgmt_pins_t  pins;
      logic        din_s1;
      logic        din_s2;
      logic [15:0] clkdiv;
      logic        poll_en;
      logic [31:0] alive;
      logic [31:0] link;
      logic        link_raw;
      logic        cmd_raw;
      logic        cmd_mask;
      logic        ucmd_go;
      logic        ucmd_write;
      logic        ucmd_ack;
      logic [4:0]  ucmd_reg;
      logic [4:0]  ucmd_phy;
      logic [15:0] ucmd_data;
      logic [4:0]  sel_phy;
      logic        sel_link_int;
      logic [31:0] prdata;
      logic        pslverr;
      logic        link_irq;
      logic        cmd_irq;
   } poller_state_t;

endpackage
`default_nettype wire

// File: phy_management_poller.sv
/*
   PHY management poller: APB register file, background poll of all PHY addresses,
   one software access at a time, and the serial management frame engine.
   Assumes an APB master on core_clk, PHYs on a shared clock plus open data wire,
   and a testbench that resolves the data wire from data_oe.
*/
// The APB interface to the registers was chosen for this implementation.
// Overview of operation
// - poll addresses 0 to 31 in turn forever while polling is enabled
// - read and write PHY registers with serial management frames on clock and data
// - keep a per-address alive map and a per-address link map
// - link change of the selected PHY sets a raw flag, masked view also offered
// - software access completion sets raw flag; masked view, mask set and clear
// - only first access and select registers work; second ones read zero
`timescale 1ns/1ns
`default_nettype none
`include "mgmt_params.svh"

module phy_management_poller
   import mgmt_pkg::*;
#(
   parameter logic [31:0] VERSION_ID = `VERSION_RESET  // arbitrary value
)
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // management bus
   output mgmt_pins_t       mgmt_pins,
   input  wire logic        mgmt_data_in,
   // event levels
   output logic             link_change_irq,
   output logic             cmd_done_irq
);

   localparam logic [16:0] MIN_HALF = 17'(`MGMT_CLK_MIN_HALF_CYC);

   localparam poller_state_t STATE_RESET = '{
      st:      ENG_IDLE,
      clkdiv:  `CLKDIV_RESET,
      poll_en: `POLL_EN_RESET,
      default: '0
   };

   poller_state_t s_reg;
   poller_state_t s_next;

   // build one 64-bit frame, first bit in the top position
   function automatic logic [63:0] build_frame(
      input logic        wr,
      input logic [4:0]  phy,
      input logic [4:0]  regad,
      input logic [15:0] data
   );
      build_frame = {`FRAME_PREAMBLE, `FRAME_START,
                     wr ? `FRAME_OP_WRITE : `FRAME_OP_READ,
                     phy, regad,
                     wr ? `FRAME_TA_WRITE : 2'b11,
                     wr ? data : `FRAME_IDLE_DATA};
   endfunction

   // register read mux
   function automatic logic [32:0] read_reg(
      input poller_state_t s,
      input logic [31:0]   addr
   );
      logic [31:0] d;
      logic        hit;
      d   = '0;
      hit = 1'b1;
      case (addr)
         `ADDR_VERSION:
            d = VERSION_ID;
         `ADDR_CONTROL:
         begin
            d[15:0]             = s.clkdiv;
            d[`CTRL_ENABLE_BIT] = s.poll_en;
            d[`CTRL_IDLE_BIT]   = (s.st == ENG_IDLE);
         end
         `ADDR_PHY_ALIVE_MAP:
            d = s.alive;
         `ADDR_PHY_LINK_MAP:
            d = s.link;
         `ADDR_LINK_IRQ_RAW:
            d[`IRQ_FIRST_MAC_BIT] = s.link_raw;
         `ADDR_LINK_IRQ_MASKED:
            d[`IRQ_FIRST_MAC_BIT] = s.link_raw & s.sel_link_int;
         `ADDR_CMD_DONE_IRQ_RAW:
            d[`IRQ_FIRST_MAC_BIT] = s.cmd_raw;
         `ADDR_CMD_DONE_IRQ_MASKED:
            d[`IRQ_FIRST_MAC_BIT] = s.cmd_raw & s.cmd_mask;
         `ADDR_CMD_DONE_MASK_SET,
         `ADDR_CMD_DONE_MASK_CLR:
            d[`IRQ_FIRST_MAC_BIT] = s.cmd_mask;
         `ADDR_ACCESS_CMD_FIRST:
         begin
            d[15:0]                         = s.ucmd_data;
            d[`CMD_PHY_LSB +: 5]            = s.ucmd_phy;
            d[`CMD_REG_LSB +: 5]            = s.ucmd_reg;
            d[`CMD_ACK_BIT]                 = s.ucmd_ack;
            d[`CMD_WRITE_BIT]               = s.ucmd_write;
            d[`CMD_GO_BIT]                  = s.ucmd_go;
         end
         `ADDR_PHY_SELECT_FIRST:
         begin
            d[`SEL_PHY_LSB +: 5]   = s.sel_phy;
            d[`SEL_LINK_INT_BIT]   = s.sel_link_int;
         end
         `ADDR_ACCESS_CMD_SECOND,
         `ADDR_PHY_SELECT_SECOND:
            d = '0;
         default:
            hit = 1'b0;
      endcase
      read_reg = {hit, d};
   endfunction

   logic [16:0] half_cyc;
   logic        half_tick;
   logic [32:0] rd;
   logic        setup_ph;
   logic        write_ph;
   logic [5:0]  bit_nx;
   logic        link_new;

   // next state
   always_comb
   begin
      s_next    = s_reg;
      half_cyc  = 17'(s_reg.clkdiv) + 17'd1;
      bit_nx    = s_reg.bit_cnt + 6'd1;
      link_new  = 1'b0;
      rd        = read_reg(s_reg, paddr);
      setup_ph  = psel & ~penable;
      write_ph  = psel & penable & pwrite;

      // half period from the divider, never below the pin minimum
      if (half_cyc < MIN_HALF)
      begin
         half_cyc = MIN_HALF;
      end
      half_tick = (s_reg.div_cnt + 17'd1 >= half_cyc);

      // data input synchroniser
      s_next.din_s1 = mgmt_data_in;
      s_next.din_s2 = s_reg.din_s1;

      // event levels
      s_next.link_irq = s_reg.link_raw & s_reg.sel_link_int;
      s_next.cmd_irq  = s_reg.cmd_raw & s_reg.cmd_mask;

      // apb read data caught in the setup cycle
      if (setup_ph)
      begin
         s_next.prdata  = pwrite ? 32'h0 : rd[31:0];
         s_next.pslverr = ~rd[32];
      end

      // apb writes take effect at the end of the access cycle
      if (write_ph)
      begin
         case (paddr)
            `ADDR_CONTROL:
            begin
               s_next.clkdiv  = pwdata[15:0];
               s_next.poll_en = pwdata[`CTRL_ENABLE_BIT];
            end
            `ADDR_PHY_ALIVE_MAP:
               s_next.alive = s_reg.alive & ~pwdata;
            `ADDR_LINK_IRQ_RAW,
            `ADDR_LINK_IRQ_MASKED:
            begin
               if (pwdata[`IRQ_FIRST_MAC_BIT])
               begin
                  s_next.link_raw = 1'b0;
               end
            end
            `ADDR_CMD_DONE_IRQ_RAW,
            `ADDR_CMD_DONE_IRQ_MASKED:
            begin
               if (pwdata[`IRQ_FIRST_MAC_BIT])
               begin
                  s_next.cmd_raw = 1'b0;
               end
            end
            `ADDR_CMD_DONE_MASK_SET:
            begin
               if (pwdata[`IRQ_FIRST_MAC_BIT])
               begin
                  s_next.cmd_mask = 1'b1;
               end
            end
            `ADDR_CMD_DONE_MASK_CLR:
            begin
               if (pwdata[`IRQ_FIRST_MAC_BIT])
               begin
                  s_next.cmd_mask = 1'b0;
               end
            end
            `ADDR_ACCESS_CMD_FIRST:
            begin
               // ignored while an access is still pending
               if (!s_reg.ucmd_go)
               begin
                  s_next.ucmd_data  = pwdata[15:0];
                  s_next.ucmd_phy   = pwdata[`CMD_PHY_LSB +: 5];
                  s_next.ucmd_reg   = pwdata[`CMD_REG_LSB +: 5];
                  s_next.ucmd_write = pwdata[`CMD_WRITE_BIT];
                  s_next.ucmd_go    = pwdata[`CMD_GO_BIT];
                  if (pwdata[`CMD_GO_BIT])
                  begin
                     s_next.ucmd_ack = 1'b0;
                  end
               end
            end
            `ADDR_PHY_SELECT_FIRST:
            begin
               s_next.sel_phy      = pwdata[`SEL_PHY_LSB +: 5];
               s_next.sel_link_int = pwdata[`SEL_LINK_INT_BIT];
            end
            default:
               s_next.pslverr = s_reg.pslverr;
         endcase
      end

      // frame engine; its flag sets come after the clears so a set wins
      case (s_reg.st)
         ENG_IDLE:
         begin
            s_next.pins.mgmt_clock_pin = 1'b0;
            s_next.pins.data_oe        = 1'b0;
            s_next.div_cnt             = '0;
            s_next.bit_cnt             = '0;
            s_next.ack                 = 1'b0;
            s_next.rdata               = '0;
            if (s_reg.ucmd_go)
            begin
               // software access goes ahead of the poll
               s_next.shift      = build_frame(s_reg.ucmd_write, s_reg.ucmd_phy,
                                               s_reg.ucmd_reg, s_reg.ucmd_data);
               s_next.is_write   = s_reg.ucmd_write;
               s_next.user_frame = 1'b1;
               s_next.st         = ENG_FRAME;
            end
            else if (s_reg.poll_en)
            begin
               s_next.shift      = build_frame(1'b0, s_reg.poll_addr,
                                               `POLL_REG_ADDR, 16'h0000);
               s_next.is_write   = 1'b0;
               s_next.user_frame = 1'b0;
               s_next.st         = ENG_FRAME;
            end
            s_next.pins.data_out = (s_next.st == ENG_FRAME) ? s_next.shift[63] : 1'b1;
            s_next.pins.data_oe  = (s_next.st == ENG_FRAME);
         end
         ENG_FRAME:
         begin
            if (!half_tick)
            begin
               s_next.div_cnt = s_reg.div_cnt + 17'd1;
            end
            else
            begin
               s_next.div_cnt = '0;
               if (!s_reg.pins.mgmt_clock_pin)
               begin
                  // rising edge: PHY input sampled
                  s_next.pins.mgmt_clock_pin = 1'b1;
                  if (s_reg.bit_cnt == `FRAME_ACK_BIT)
                  begin
                     s_next.ack = ~s_reg.din_s2;
                  end
                  if (s_reg.bit_cnt >= `FRAME_DATA_FIRST_BIT)
                  begin
                     s_next.rdata = {s_reg.rdata[14:0], s_reg.din_s2};
                  end
               end
               else
               begin
                  // falling edge: next bit driven or frame ended
                  s_next.pins.mgmt_clock_pin = 1'b0;
                  if (s_reg.bit_cnt == `FRAME_LAST_BIT)
                  begin
                     s_next.st           = ENG_IDLE;
                     s_next.pins.data_oe = 1'b0;
                     if (s_reg.user_frame)
                     begin
                        s_next.ucmd_go  = 1'b0;
                        s_next.ucmd_ack = s_reg.ack;
                        s_next.cmd_raw  = 1'b1;
                        if (!s_reg.is_write)
                        begin
                           s_next.ucmd_data = s_reg.rdata;
                        end
                     end
                     else
                     begin
                        link_new = s_reg.ack & s_reg.rdata[`LINK_STATUS_BIT];
                        s_next.alive[s_reg.poll_addr] = s_reg.ack;
                        s_next.link[s_reg.poll_addr]  = link_new;
                        if ((link_new != s_reg.link[s_reg.poll_addr]) &&
                            (s_reg.poll_addr == s_reg.sel_phy))
                        begin
                           s_next.link_raw = 1'b1;
                        end
                        s_next.poll_addr = s_reg.poll_addr + 5'd1;
                     end
                  end
                  else
                  begin
                     s_next.bit_cnt       = bit_nx;
                     s_next.shift         = {s_reg.shift[62:0], 1'b1};
                     s_next.pins.data_out = s_reg.shift[62];
                     s_next.pins.data_oe  = s_reg.is_write | (bit_nx < `FRAME_RELEASE_BIT);
                  end
               end
            end
         end
         default:
            s_next.st = ENG_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         s_reg <= STATE_RESET;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // outputs
   assign pready          = psel & penable; // zero wait states
   assign prdata          = s_reg.prdata;
   assign pslverr         = s_reg.pslverr;
   assign mgmt_pins       = s_reg.pins;
   assign link_change_irq = s_reg.link_irq;
   assign cmd_done_irq    = s_reg.cmd_irq;

endmodule
`default_nettype wire

// File: phy_management_poller_chk.sv
/*
   Port checker for the PHY management poller, bound to its top module.
   Assumes mgmt_pkg, mgmt_params.svh and one core_clk domain.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mgmt_params.svh"
module phy_management_poller_chk
   import mgmt_pkg::*;
(
   // clock and reset
   input wire logic        core_clk,
   input wire logic        reset,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // management bus and events
   input wire mgmt_pins_t  mgmt_pins,
   input wire logic        mgmt_data_in,
   input wire logic        link_change_irq,
   input wire logic        cmd_done_irq
);
   localparam int HALF_MIN = `MGMT_CLK_MIN_HALF_CYC;
   logic [15:0] hi_cnt;
   logic [15:0] lo_cnt;
   logic        mclk;
   logic        setup;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   assign mclk = mgmt_pins.mgmt_clock_pin;
   assign setup = psel && !penable;
   // cycles spent at the present clock level
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         hi_cnt <= '0;
         lo_cnt <= '0;
      end
      else
      begin
         hi_cnt <= mclk ? hi_cnt + 16'h0001 : 16'h0000;
         lo_cnt <= mclk ? 16'h0000 : lo_cnt + {15'h0000, ~&lo_cnt};
      end
   end
   property p_pready; pready == (psel && penable); endproperty
   a_pready: assert property (p_pready) else $error("pready not equal to access phase");
   property p_second_zero;
      setup && !pwrite && (paddr == `ADDR_ACCESS_CMD_SECOND || paddr == `ADDR_PHY_SELECT_SECOND)
      |=> prdata == 32'h00000000 && !pslverr;
   endproperty
   a_second_zero: assert property (p_second_zero) else $error("second register not zero");
   property p_unmapped; setup && paddr == 32'h01c83838 |=> pslverr && prdata == 32'h00000000; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access without error");
   property p_mask_clr;
      psel && penable && pwrite && paddr == `ADDR_CMD_DONE_MASK_CLR && pwdata[0] |-> ##2 !cmd_done_irq;
   endproperty
   a_mask_clr: assert property (p_mask_clr) else $error("event level kept after mask clear");
   property p_data_on_fall; $changed(mgmt_pins.data_out) |-> !mclk; endproperty
   a_data_on_fall: assert property (p_data_on_fall) else $error("data moved with clock high");
   property p_frame_start; $rose(mgmt_pins.data_oe) |-> (mgmt_pins.data_out && !mclk) [*8]; endproperty
   a_frame_start: assert property (p_frame_start) else $error("frame not opened by preamble");
   property p_release_low; $fell(mgmt_pins.data_oe) |-> !mclk; endproperty
   a_release_low: assert property (p_release_low) else $error("data released with clock high");
   property p_hi_half; $fell(mclk) |-> hi_cnt >= HALF_MIN; endproperty
   a_hi_half: assert property (p_hi_half) else $error("clock high phase too short");
   property p_lo_half; $rose(mclk) |-> lo_cnt >= HALF_MIN; endproperty
   a_lo_half: assert property (p_lo_half) else $error("clock low phase too short");
endmodule
bind phy_management_poller phy_management_poller_chk chk
(
   .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .mgmt_pins(mgmt_pins),
   .mgmt_data_in(mgmt_data_in), .link_change_irq(link_change_irq), .cmd_done_irq(cmd_done_irq)
);
`default_nettype wire

// File: phy_management_poller_tb_top.sv
/*
   Testbench for the PHY management poller: APB tasks and register scenarios.
   Assumes mgmt_pkg, mgmt_params.svh, phy_mgmt_model and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mgmt_params.svh"
module phy_management_poller_tb_top
   import mgmt_pkg::*;
;
   localparam logic [31:0] ALL = 32'hffffffff;
   logic        core_clk, reset, psel, penable, pwrite, pready, pslverr, err;
   logic        link_change_irq, cmd_done_irq, mdio_wire, phy_oe, phy_out;
   logic [31:0] paddr, pwdata, prdata, rdata;
   mgmt_pins_t  mgmt_pins;
   int          errors, total_checks;
   // open data wire with pull-up
   assign mdio_wire = mgmt_pins.data_oe ? mgmt_pins.data_out : (phy_oe ? phy_out : 1'b1);
   phy_management_poller uut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .mgmt_pins(mgmt_pins), .mgmt_data_in(mdio_wire), .link_change_irq(link_change_irq),
      .cmd_done_irq(cmd_done_irq));
   phy_mgmt_model phy (.mgmt_clk(mgmt_pins.mgmt_clock_pin), .mdio(mdio_wire), .drv_oe(phy_oe), .drv_out(phy_out));
   // core clock
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask
   // one apb transfer, held until pready is seen high
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16)
      begin
         errors++;
         conclude();
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      xfer(1'b1, a, d, r, e);
      chk("write_error", 32'h0, {31'h0, e});
   endtask
   task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      xfer(1'b0, a, 32'h0, r, e);
      chk(name, exp, r & m);
   endtask
   // poll a register until the masked value appears, bounded
   task automatic wait_reg(input logic [31:0] a, input logic [31:0] m, input logic [31:0] want);
      logic [31:0] r;
      logic        e;
      int          n;
      n = 0;
      do
      begin
         xfer(1'b0, a, 32'h0, r, e);
         n++;
      end
      while ((r & m) !== want && n < 8000);
      if (n >= 8000)
      begin
         errors++;
         conclude();
      end
   endtask
   function automatic logic [31:0] cmd(input logic go, input logic w, input logic ack, input logic [4:0] rg,
                                       input logic [4:0] p, input logic [15:0] d);
      return {go, w, ack, 3'h0, rg, p, d};
   endfunction
   // main sequence
   initial
   begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      errors = 0;
      total_checks = 0;
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      rd_chk("version", `ADDR_VERSION, ALL, `VERSION_RESET);
      rd_chk("control", `ADDR_CONTROL, 32'h7fffffff, 32'h40000031);
      rd_chk("mask", `ADDR_CMD_DONE_MASK_SET, ALL, 32'h0);
      rd_chk("cmd_second", `ADDR_ACCESS_CMD_SECOND, ALL, 32'h0);
      rd_chk("sel_second", `ADDR_PHY_SELECT_SECOND, ALL, 32'h0);
      xfer(1'b0, 32'h01c83838, 32'h0, rdata, err);
      chk("unmapped", 32'h1, {31'h0, err});
      xfer(1'b1, 32'h01c83838, ALL, rdata, err);
      chk("unmapped_wr", 32'h1, {31'h0, err});
      wr(`ADDR_CONTROL, 32'h40000000);
      wr(`ADDR_PHY_SELECT_FIRST, 32'h00000043);
      wr(`ADDR_CMD_DONE_MASK_SET, 32'h1);
      wr(`ADDR_ACCESS_CMD_FIRST, cmd(1, 1, 0, 5'h4, 5'h1, 16'h1234));
      wait_reg(`ADDR_ACCESS_CMD_FIRST, 32'h80000000, 32'h0);
      chk("phy_write", 32'h1234, {16'h0, phy.scratch[1]});
      rd_chk("cmd_masked", `ADDR_CMD_DONE_IRQ_MASKED, 32'h1, 32'h1);
      chk("cmd_irq", 32'h1, {31'h0, cmd_done_irq});
      wr(`ADDR_CMD_DONE_MASK_CLR, 32'h1);
      repeat (2) @(posedge core_clk);
      chk("cmd_irq_off", 32'h0, {31'h0, cmd_done_irq});
      rd_chk("cmd_masked_off", `ADDR_CMD_DONE_IRQ_MASKED, 32'h1, 32'h0);
      rd_chk("cmd_raw", `ADDR_CMD_DONE_IRQ_RAW, 32'h1, 32'h1);
      wr(`ADDR_CMD_DONE_IRQ_RAW, 32'h1);
      rd_chk("cmd_raw_clr", `ADDR_CMD_DONE_IRQ_RAW, 32'h1, 32'h0);
      wr(`ADDR_ACCESS_CMD_FIRST, cmd(1, 0, 0, 5'h4, 5'h1, 16'h0));
      wait_reg(`ADDR_ACCESS_CMD_FIRST, 32'h80000000, 32'h0);
      rd_chk("read_back", `ADDR_ACCESS_CMD_FIRST, ALL, cmd(0, 0, 1, 5'h4, 5'h1, 16'h1234));
      wr(`ADDR_ACCESS_CMD_FIRST, cmd(1, 0, 0, 5'h4, 5'h2, 16'h0));
      wait_reg(`ADDR_ACCESS_CMD_FIRST, 32'h80000000, 32'h0);
      rd_chk("absent", `ADDR_ACCESS_CMD_FIRST, ALL, cmd(0, 0, 0, 5'h4, 5'h2, 16'hffff));
      // background poll reaches phy 3, which has link
      wait_reg(`ADDR_PHY_ALIVE_MAP, 32'h8, 32'h8);
      chk("polled", 32'hf, phy.polled & 32'hf);
      rd_chk("alive", `ADDR_PHY_ALIVE_MAP, 32'hf, 32'ha);
      rd_chk("link", `ADDR_PHY_LINK_MAP, ALL, 32'h8);
      rd_chk("link_raw", `ADDR_LINK_IRQ_RAW, ALL, 32'h1);
      rd_chk("link_masked", `ADDR_LINK_IRQ_MASKED, ALL, 32'h1);
      chk("link_irq", 32'h1, {31'h0, link_change_irq});
      wr(`ADDR_LINK_IRQ_RAW, 32'h1);
      rd_chk("link_masked_clr", `ADDR_LINK_IRQ_MASKED, ALL, 32'h0);
      // stop polling: the engine ends its frame and stays idle
      wr(`ADDR_CONTROL, 32'h00000000);
      wait_reg(`ADDR_CONTROL, 32'h80000000, 32'h80000000);
      rd_chk("poll_off", `ADDR_CONTROL, 32'h4000ffff, 32'h0);
      wr(`ADDR_PHY_ALIVE_MAP, ALL);
      rd_chk("alive_clr", `ADDR_PHY_ALIVE_MAP, ALL, 32'h0);
      conclude();
   end
endmodule
`default_nettype wire

// File: phy_mgmt_model.sv
/*
   Behavioural PHYs on the shared management bus: answers reads, keeps writes.
   Assumes a pulled-up data wire resolved by the testbench.
*/
`timescale 1ns/1ns
`default_nettype none
module phy_mgmt_model
#(
   parameter logic [31:0] PRESENT = 32'h0000000a,
   parameter logic [31:0] LINKED  = 32'h00000008
)
(
   // bus side
   input wire logic mgmt_clk,
   input wire logic mdio,
   output logic     drv_oe,
   output logic     drv_out
);
   logic [6:0]  pos;
   logic        prev;
   logic        is_rd;
   logic [4:0]  phy;
   logic [11:0] hdr;
   logic [15:0] wdat;
   logic [15:0] rdat;
   logic [31:0] polled;
   logic [15:0] scratch [32];
   initial
   begin
      pos = 0;
      prev = 1'b1;
      drv_oe = 1'b0;
      drv_out = 1'b0;
      polled = '0;
      foreach (scratch[i]) scratch[i] = 16'h0000;
   end
   // sample on rising clock, find start pattern, decode header
   always @(posedge mgmt_clk)
   begin
      if (pos == 0)
      begin
         if (!prev && mdio) pos = 33;
         prev = mdio;
      end
      else
      begin
         pos = pos + 7'd1;
         hdr = {hdr[10:0], mdio};
         if (pos >= 48) wdat = {wdat[14:0], mdio};
         if (pos == 45)
         begin
            is_rd = (hdr[11:10] == 2'b10);
            phy = hdr[9:5];
            if (is_rd && hdr[4:0] == 5'h01) polled[phy] = 1'b1;
            rdat = (hdr[4:0] == 5'h01) ? {13'h0000, LINKED[phy], 2'b00} : scratch[phy];
         end
         if (pos == 63)
         begin
            if (!is_rd && PRESENT[phy]) scratch[phy] = wdat;
            pos = 0;
            prev = 1'b1;
         end
      end
   end
   // drive acknowledge and read data after falling clock, then release
   always @(negedge mgmt_clk)
   begin
      if (pos == 46 && is_rd && PRESENT[phy])
      begin
         drv_oe = 1'b1;
         drv_out = 1'b0;
      end
      else if (drv_oe && pos >= 47 && pos <= 62) drv_out = rdat[62 - pos];
      else drv_oe = 1'b0;
   end
endmodule
`default_nettype wire
